// [uat_transmitter.sv]
// Purpose: Asynchronous serial transmitter with a one-deep buffer and a shift register.
// Assumes: Software controls arrive as same-clock levels; a write is a one-cycle strobe.
// Notes:   A character is loaded straight into the shifter when it is idle.
//
// Overview of operation
// - Idle line held at mark level.
// - Frame: start, eight/nine data, stop.
// - LSB first, each bit one baud period.
// - Bit rate from 8/16-bit clock divisor.
// - No hardware parity; ninth bit carries it.
// - Active only with enable, async, port on.
// - Port enable forces pin to drive.
// - Disabled port releases pin to general I/O.
// - Enabling transmit sets buffer-empty flag.
// - Write to idle shifter loads at once.
// - Queued character loads right after stop.
// - Empty flag clear only while inactive or queued behind busy.
// - Flag valid by second cycle after write.
// - Flag independent of its interrupt enable.
// - Software disables interrupt after last character.
// - Shifter-empty status clears during character.
// - Nine-bit select sends ninth bit last.
// - Software writes ninth bit before data.
// - Ninth bit one marks an address.
// - Software follows the documented setup order.
// - Enabled interrupt fires at once when empty.
`timescale 1ns/1ns
module uat_transmitter
  import uat_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       nrst,
  // Serial line.
  uat_line_if.transmitter line,
  // Transmit control.
  input  wire logic       transmitEnable,
  input  wire logic       syncSelect,
  input  wire logic       serialPortEnable,
  input  wire logic       nineBitTxSelect,
  input  wire logic       txNinthDataBit,
  // Baud divisor.
  input  wire logic [7:0] baudDivisorLow,
  input  wire logic [7:0] baudDivisorHigh,
  input  wire logic       baudWideDivisorSelect,
  input  wire logic       baudHighSpeedSelect,
  // Buffer write.
  input  wire logic       dataWrite,
  input  wire logic [7:0] dataWriteValue,
  // Interrupt enables.
  input  wire logic       txEmptyIrqEnable,
  input  wire logic       peripheralIrqEnable,
  input  wire logic       globalIrqEnable,
  // Status and interrupt.
  output logic            txBufferEmptyFlag,
  output logic            shifterEmptyStatus,
  output logic            txIrqRequest,
  // General-purpose port logic sharing the pin.
  input  wire logic       gpioOut,
  input  wire logic       gpioOe,
  output logic            gpioIn
);
  import uat_pkg::*;

  // ==========================================================================
  // Control decode
  // ==========================================================================
  logic                 txActive;
  logic [BIT_CNT_W-1:0] bitLenM1;
  logic                 bitDone;

  // All three controls must agree before any character moves.
  assign txActive = transmitEnable && !syncSelect && serialPortEnable;
  assign bitLenM1 = uat_bit_len_m1(baudDivisorLow, baudDivisorHigh,
                                   baudWideDivisorSelect, baudHighSpeedSelect);

  // ==========================================================================
  // State
  // ==========================================================================
  uat_state_type        state_q;
  logic [BIT_CNT_W-1:0] baudCnt_q;
  logic [8:0]           shift_q;
  logic [3:0]           bitIdx_q;
  logic                 nine_q;
  logic                 bufFull_q;
  logic [8:0]           buf_q;
  logic                 lineOut_q;
  logic                 gpioMeta_q;
  logic                 gpioIn_q;
  logic                 loadFromWrite;
  logic                 loadFromBuf;
  logic                 frameEnd;
  logic [3:0]           lastIdx;

  assign bitDone  = (baudCnt_q == bitLenM1);
  assign lastIdx  = nine_q ? LAST_BIT_9 : LAST_BIT_8;
  // The stop bit must run its whole period before a frame ends.
  assign frameEnd = (state_q == UAT_STOP) && bitDone;
  // An idle shifter with nothing queued takes the write directly.
  assign loadFromWrite = txActive && dataWrite && !bufFull_q &&
                         ((state_q == UAT_IDLE) || frameEnd);
  // A queued character moves in the cycle the stop bit ends.
  assign loadFromBuf = txActive && bufFull_q &&
                       ((state_q == UAT_IDLE) || frameEnd);

  // Transmit buffer holds one character plus its ninth bit.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bufFull_q <= 1'b0;
      buf_q     <= 9'h000;
    end else if (!txActive) begin
      bufFull_q <= 1'b0;
    end else if (dataWrite && !bufFull_q && !loadFromWrite) begin
      // The ninth bit is sampled with the data, so it must be set up first.
      bufFull_q <= 1'b1;
      buf_q     <= {txNinthDataBit, dataWriteValue};
    end else if (loadFromBuf) begin
      bufFull_q <= 1'b0;
    end
  end

  // Frame sequencer. Disabling the transmitter abandons any frame in flight.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q   <= UAT_IDLE;
      baudCnt_q <= '0;
      shift_q   <= 9'h000;
      bitIdx_q  <= BIT_IDX_FIRST;
      nine_q    <= 1'b0;
      lineOut_q <= RESET_LINE;
    end else if (!txActive) begin
      state_q   <= UAT_IDLE;
      baudCnt_q <= '0;
      lineOut_q <= LINE_MARK;
    end else if (loadFromWrite || loadFromBuf) begin
      // All nine bits enter the shifter together; no parity is added.
      shift_q   <= loadFromBuf ? buf_q : {txNinthDataBit, dataWriteValue};
      nine_q    <= nineBitTxSelect;
      state_q   <= UAT_START;
      baudCnt_q <= '0;
      bitIdx_q  <= BIT_IDX_FIRST;
      lineOut_q <= LINE_SPACE;
    end else if (state_q != UAT_IDLE) begin
      if (!bitDone) begin
        baudCnt_q <= baudCnt_q + 23'h00_0001;
      end else begin
        baudCnt_q <= '0;
        case (state_q)
          UAT_START: begin
            state_q   <= UAT_DATA;
            lineOut_q <= shift_q[0];
          end
          UAT_DATA: begin
            if (bitIdx_q == lastIdx) begin
              state_q   <= UAT_STOP;
              lineOut_q <= LINE_MARK;
            end else begin
              shift_q   <= {1'b0, shift_q[8:1]};
              bitIdx_q  <= bitIdx_q + 4'h1;
              lineOut_q <= shift_q[1];
            end
          end
          default: begin
            state_q   <= UAT_IDLE;
            lineOut_q <= LINE_MARK;
          end
        endcase
      end
    end
  end

  // Port input seen through two flops before general-purpose logic reads it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gpioMeta_q <= 1'b1;
      gpioIn_q   <= 1'b1;
    end else begin
      gpioMeta_q <= line.lineLevel;
      gpioIn_q   <= gpioMeta_q;
    end
  end

  // ==========================================================================
  // Pin ownership and status
  // ==========================================================================
  // The port enable takes the pin even with the transmitter off; it then idles at mark.
  assign line.pinOe  = serialPortEnable ? 1'b1 : gpioOe;
  assign line.pinOut = serialPortEnable ? lineOut_q : gpioOut;
  assign gpioIn      = gpioIn_q;

  // The flag follows buffer occupancy only; it rises as soon as enable does.
  assign txBufferEmptyFlag  = txActive && !bufFull_q;
  assign shifterEmptyStatus = (state_q == UAT_IDLE);
  // Gating by the enables alone, so an empty buffer interrupts at once.
  assign txIrqRequest = txBufferEmptyFlag && txEmptyIrqEnable &&
                        peripheralIrqEnable && globalIrqEnable;

endmodule

// [uat_pkg.sv]
// Purpose: Shared constants, state type and bit-timing helper for the serial transmit link.
// Assumes: One 100 MHz clock; both ends use the same divisor settings and data format.
// Notes:   Bit length in clocks is (divisor + 1) scaled by a power-of-two prescale.
package uat_pkg;

  // ==========================================================================
  // Clocking and line levels
  // ==========================================================================
  localparam int         CLK_FREQ_HZ   = 100_000_000;
  localparam logic       LINE_MARK     = 1'b1;
  localparam logic       LINE_SPACE    = 1'b0;
  localparam logic       RESET_LINE    = LINE_MARK;

  // ==========================================================================
  // Bit timing
  // ==========================================================================
  localparam int         BIT_CNT_W     = 23;
  localparam logic [2:0] SHIFT_SLOW    = 3'h6;
  localparam logic [2:0] SHIFT_MID     = 3'h4;
  localparam logic [2:0] SHIFT_FAST    = 3'h2;

  // ==========================================================================
  // Frame format
  // ==========================================================================
  localparam logic [3:0] LAST_BIT_8    = 4'h7;
  localparam logic [3:0] LAST_BIT_9    = 4'h8;
  localparam logic [3:0] BIT_IDX_FIRST = 4'h0;

  // Gray coded along idle, start, data, stop.
  typedef enum logic [1:0] {
    UAT_IDLE  = 2'b00,
    UAT_START = 2'b01,
    UAT_DATA  = 2'b11,
    UAT_STOP  = 2'b10
  } uat_state_type;

  // Clocks per bit minus one. The narrow divisor ignores the high byte.
  function automatic logic [BIT_CNT_W-1:0] uat_bit_len_m1(
    input logic [7:0] divLow,
    input logic [7:0] divHigh,
    input logic       wideSel,
    input logic       highSpeed
  );
    logic [16:0] divPlus1;
    logic [2:0]  sh;
    divPlus1 = {1'b0, (wideSel ? divHigh : 8'h00), divLow} + 17'h0_0001;
    sh       = (wideSel && highSpeed) ? SHIFT_FAST :
               (wideSel || highSpeed) ? SHIFT_MID : SHIFT_SLOW;
    return ({6'h00, divPlus1} << sh) - 23'h00_0001;
  endfunction

endpackage

// [uat_line_if.sv]
// Purpose: Serial transmit line between the transmitter and a remote receiver.
// Assumes: The pin is pulled to mark level whenever nobody drives it.
// Notes:   The resolved level is the only thing the receiver sees.
`timescale 1ns/1ns
interface uat_line_if;
  logic pinOut;
  logic pinOe;
  logic lineLevel;

  // A released pin floats up to mark through the pull-up.
  assign lineLevel = pinOe ? pinOut : 1'b1;

  modport transmitter (output pinOut, output pinOe, input lineLevel);
  modport receiver (input lineLevel);
endinterface

// [uat_receiver.sv]
// Purpose: Remote asynchronous receiver on the transmit line.
// Assumes: Same divisor settings and data format as the transmitter.
// Notes:   Samples each bit at its middle; stop is one bit long.
`timescale 1ns/1ns
module uat_receiver
  import uat_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       nrst,
  // Serial line.
  uat_line_if.receiver    line,
  // Receive control.
  input  wire logic       receiveEnable,
  input  wire logic       nineBitRxSelect,
  input  wire logic       addressDetectEnable,
  // Baud divisor.
  input  wire logic [7:0] baudDivisorLow,
  input  wire logic [7:0] baudDivisorHigh,
  input  wire logic       baudWideDivisorSelect,
  input  wire logic       baudHighSpeedSelect,
  // Received character.
  output logic            rxValid,
  output logic [7:0]      rxData,
  output logic            rxNinthBit,
  output logic            rxIsAddress,
  output logic            rxFramingError
);
  import uat_pkg::*;

  // ==========================================================================
  // Line synchroniser and timing
  // ==========================================================================
  logic                 lineMeta_q;
  logic                 lineSync_q;
  uat_state_type        state_q;
  logic [BIT_CNT_W-1:0] cnt_q;
  logic [BIT_CNT_W-1:0] bitLenM1;
  logic [8:0]           shift_q;
  logic [3:0]           bitIdx_q;
  logic [3:0]           lastIdx;
  logic                 sampleNow;

  assign bitLenM1  = uat_bit_len_m1(baudDivisorLow, baudDivisorHigh,
                                    baudWideDivisorSelect, baudHighSpeedSelect);
  // The start bit is checked at half a bit, the rest one full bit apart.
  assign sampleNow = (state_q == UAT_START) ? (cnt_q == {1'b0, bitLenM1[BIT_CNT_W-1:1]})
                                            : (cnt_q == bitLenM1);
  assign lastIdx   = nineBitRxSelect ? LAST_BIT_9 : LAST_BIT_8;

  // The line comes from another device, so two flops guard it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lineMeta_q <= LINE_MARK;
      lineSync_q <= LINE_MARK;
    end else begin
      lineMeta_q <= line.lineLevel;
      lineSync_q <= lineMeta_q;
    end
  end

  // ==========================================================================
  // Frame recovery
  // ==========================================================================
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q        <= UAT_IDLE;
      cnt_q          <= '0;
      shift_q        <= 9'h000;
      bitIdx_q       <= BIT_IDX_FIRST;
      rxValid        <= 1'b0;
      rxData         <= 8'h00;
      rxNinthBit     <= 1'b0;
      rxIsAddress    <= 1'b0;
      rxFramingError <= 1'b0;
    end else begin
      rxValid <= 1'b0;
      if (!receiveEnable) begin
        state_q <= UAT_IDLE;
        cnt_q   <= '0;
      end else if (state_q == UAT_IDLE) begin
        cnt_q <= '0;
        if (lineSync_q == LINE_SPACE) begin
          state_q <= UAT_START;
        end
      end else if (!sampleNow) begin
        cnt_q <= cnt_q + 23'h00_0001;
      end else begin
        cnt_q <= '0;
        case (state_q)
          UAT_START: begin
            // A glitch shorter than half a bit is dropped silently.
            state_q  <= (lineSync_q == LINE_SPACE) ? UAT_DATA : UAT_IDLE;
            bitIdx_q <= BIT_IDX_FIRST;
            shift_q  <= 9'h000;
          end
          UAT_DATA: begin
            // Bits arrive least significant first and fill from the top down.
            if (nineBitRxSelect) begin
              shift_q <= {lineSync_q, shift_q[8:1]};
            end else begin
              shift_q <= {1'b0, lineSync_q, shift_q[7:1]};
            end
            bitIdx_q <= bitIdx_q + 4'h1;
            if (bitIdx_q == lastIdx) begin
              state_q <= UAT_STOP;
            end
          end
          default: begin
            state_q <= UAT_IDLE;
            // With address detection on, only address characters are delivered.
            if (!addressDetectEnable || (nineBitRxSelect && shift_q[8])) begin
              rxValid        <= 1'b1;
              rxData         <= shift_q[7:0];
              rxNinthBit     <= shift_q[8];
              rxIsAddress    <= nineBitRxSelect && shift_q[8];
              rxFramingError <= (lineSync_q != LINE_MARK);
            end
          end
        endcase
      end
    end
  end

endmodule

// [uat_link_checker.sv]
// Purpose: Concurrent checks on the serial line and the transmitter status.
// Assumes: One clock domain; a bit lasts at least four clocks.
// Notes:   The bench instantiates it beside the line interface.
`timescale 1ns/1ns
module uat_link_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Line.
  input wire logic pinOut,
  input wire logic pinOe,
  input wire logic lineLevel,
  // Controls.
  input wire logic transmitEnable,
  input wire logic syncSelect,
  input wire logic serialPortEnable,
  input wire logic dataWrite,
  input wire logic txEmptyIrqEnable,
  input wire logic peripheralIrqEnable,
  input wire logic globalIrqEnable,
  input wire logic gpioOut,
  input wire logic gpioOe,
  // Status.
  input wire logic txBufferEmptyFlag,
  input wire logic shifterEmptyStatus,
  input wire logic txIrqRequest
);
  logic active;

  // One term for the three enables keeps the properties short.
  assign active = transmitEnable && !syncSelect && serialPortEnable;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // ==========================================================================
  // Pin and line level
  // ==========================================================================
  chk_port_owns_pin: assert property (serialPortEnable |-> pinOe)
    else $error("pin released while port enabled");
  chk_gpio_release: assert property (!serialPortEnable |->
    pinOe == gpioOe && lineLevel == (gpioOe ? gpioOut : 1'b1))
    else $error("pin not handed to port logic");
  chk_idle_mark: assert property (serialPortEnable && shifterEmptyStatus |-> lineLevel)
    else $error("idle line not at mark");
  // The fall is seen one clock into the start bit, so at the shortest bit four sampled
  // clocks remain and three are checked; a zero first data bit would hide any longer overrun.
  chk_start_space: assert property ($fell(shifterEmptyStatus) && serialPortEnable |->
    (!pinOut) [*3])
    else $error("start bit not space for a full bit");
  chk_stop_mark: assert property ($rose(shifterEmptyStatus) && active |->
    $past(pinOut) && $past(pinOut, 4))
    else $error("frame ended without a mark stop bit");

  // ==========================================================================
  // Buffer-empty flag and interrupt
  // ==========================================================================
  chk_flag_inactive: assert property (!active |-> !txBufferEmptyFlag)
    else $error("flag set while transmitter inactive");
  chk_enable_flag: assert property ($rose(transmitEnable) && active |-> txBufferEmptyFlag)
    else $error("flag not set on enable");
  chk_flag_idle: assert property (active && shifterEmptyStatus |-> txBufferEmptyFlag)
    else $error("flag clear with idle shifter");
  chk_flag_fall: assert property ($fell(txBufferEmptyFlag) && active |-> $past(dataWrite))
    else $error("flag fell without a write");
  chk_irq_gate: assert property (txIrqRequest == (txBufferEmptyFlag &&
    txEmptyIrqEnable && peripheralIrqEnable && globalIrqEnable))
    else $error("interrupt request not gated by flag and enables");

  // Main scenarios reached.
  cover property ($fell(shifterEmptyStatus));
  cover property ($fell(txBufferEmptyFlag));
  cover property (txIrqRequest);
endmodule

// [tb.sv]
// Purpose: Self-checking bench joining the transmitter to the receiver over the line.
// Assumes: Inputs change at the falling edge; the receiver decodes what was sent.
// Notes:   Expected characters and their spacing wait in queues for the monitor.
`timescale 1ns/1ns
module tb;
  logic       clk, nrst, transmitEnable, syncSelect, serialPortEnable;
  logic       nineBitTxSelect, txNinthDataBit, baudWideDivisorSelect, baudHighSpeedSelect;
  logic       dataWrite, txEmptyIrqEnable, peripheralIrqEnable, globalIrqEnable;
  logic       gpioOut, gpioOe, receiveEnable, nineBitRxSelect, addressDetectEnable;
  logic [7:0] baudDivisorLow, baudDivisorHigh, dataWriteValue, rnd, rxData;
  logic       txBufferEmptyFlag, shifterEmptyStatus, txIrqRequest, gpioIn;
  logic       rxValid, rxNinthBit, rxIsAddress, rxFramingError;
  logic [9:0] expQ[$];
  logic [9:0] expE;
  int         gapQ[$];
  int         expG, L, cyc = 0, lastT = 0, n_fail = 0, tests_run = 0;

  uat_line_if uat_line_if_inst ();
  uat_transmitter uat_transmitter_inst (.clk(clk), .nrst(nrst),
    .line(uat_line_if_inst.transmitter), .transmitEnable(transmitEnable),
    .syncSelect(syncSelect), .serialPortEnable(serialPortEnable),
    .nineBitTxSelect(nineBitTxSelect), .txNinthDataBit(txNinthDataBit),
    .baudDivisorLow(baudDivisorLow), .baudDivisorHigh(baudDivisorHigh),
    .baudWideDivisorSelect(baudWideDivisorSelect), .baudHighSpeedSelect(baudHighSpeedSelect),
    .dataWrite(dataWrite), .dataWriteValue(dataWriteValue), .txEmptyIrqEnable(txEmptyIrqEnable),
    .peripheralIrqEnable(peripheralIrqEnable), .globalIrqEnable(globalIrqEnable),
    .txBufferEmptyFlag(txBufferEmptyFlag), .shifterEmptyStatus(shifterEmptyStatus),
    .txIrqRequest(txIrqRequest), .gpioOut(gpioOut), .gpioOe(gpioOe), .gpioIn(gpioIn));
  uat_receiver uat_receiver_inst (.clk(clk), .nrst(nrst), .line(uat_line_if_inst.receiver),
    .receiveEnable(receiveEnable), .nineBitRxSelect(nineBitRxSelect),
    .addressDetectEnable(addressDetectEnable), .baudDivisorLow(baudDivisorLow),
    .baudDivisorHigh(baudDivisorHigh), .baudWideDivisorSelect(baudWideDivisorSelect),
    .baudHighSpeedSelect(baudHighSpeedSelect), .rxValid(rxValid), .rxData(rxData),
    .rxNinthBit(rxNinthBit), .rxIsAddress(rxIsAddress), .rxFramingError(rxFramingError));
  uat_link_checker uat_link_checker_inst (.clk(clk), .nrst(nrst),
    .pinOut(uat_line_if_inst.pinOut), .pinOe(uat_line_if_inst.pinOe),
    .lineLevel(uat_line_if_inst.lineLevel), .transmitEnable(transmitEnable),
    .syncSelect(syncSelect), .serialPortEnable(serialPortEnable), .dataWrite(dataWrite),
    .txEmptyIrqEnable(txEmptyIrqEnable), .peripheralIrqEnable(peripheralIrqEnable),
    .globalIrqEnable(globalIrqEnable), .gpioOut(gpioOut), .gpioOe(gpioOe),
    .txBufferEmptyFlag(txBufferEmptyFlag), .shifterEmptyStatus(shifterEmptyStatus),
    .txIrqRequest(txIrqRequest));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Eight-bit shift register sequence; the taps never reach the all-zero lock.
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Clocks per bit for the divisor now applied.
  function automatic int bitLen();
    logic [16:0] d;
    d = (baudWideDivisorSelect ? {1'b0, baudDivisorHigh, baudDivisorLow} : {9'h000, baudDivisorLow})
      + 17'h0_0001;
    return int'(d) << ((baudWideDivisorSelect && baudHighSpeedSelect) ? 2 :
      (baudWideDivisorSelect || baudHighSpeedSelect) ? 4 : 6);
  endfunction

  task automatic chkLvl(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s", $time, what);
    end
  endtask

  task automatic chkChar(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t character %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkGap(input int got, input int exp);
    tests_run++;
    if (got != exp) begin
      n_fail++;
      $display("BAD %0t frame spacing %0d expected %0d", $time, got, exp);
    end
  endtask

  // Waits for room in the buffer, then writes; a write to an idle shifter starts at once.
  task automatic send(input logic [8:0] v, input int gap, input bit push);
    logic idle;
    // One idle edge first, so a strobe just lowered is never raised in the same step.
    do @(negedge clk); while (txBufferEmptyFlag !== 1'b1);
    idle = shifterEmptyStatus;
    txNinthDataBit = v[8];
    dataWriteValue = v[7:0];
    dataWrite = 1'b1;
    if (push) begin
      expQ.push_back({nineBitTxSelect, v});
      gapQ.push_back(gap);
    end
    @(negedge clk);
    dataWrite = 1'b0;
    if (idle === 1'b1) chkLvl(shifterEmptyStatus, 1'b0, "shifter not loaded");
  endtask

  task automatic waitIdle();
    while (expQ.size() != 0 || shifterEmptyStatus !== 1'b1) @(negedge clk);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Monitor and timeout
  // ==========================================================================
  // Each received character retires the oldest note; the ceiling covers the longest mode.
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      $display("BAD %0t timeout", $time);
      end_sim();
    end
    if (rxValid === 1'b1) begin
      if (expQ.size() == 0) begin
        n_fail++;
        $display("BAD %0t unexpected character", $time);
      end else begin
        expE = expQ.pop_front();
        expG = gapQ.pop_front();
        chkChar(expE[9] ? {rxIsAddress, rxNinthBit, rxData} : {2'b00, rxData},
          {expE[9] & expE[8], expE[9] & expE[8], expE[7:0]});
        if (expG != 0) chkGap(cyc - lastT, expG);
        chkLvl(rxFramingError, 1'b0, "stop bit not mark");
      end
      lastT = cyc;
    end
  end

  // ==========================================================================
  // Stimulus
  // ==========================================================================
  initial begin
    {transmitEnable, syncSelect, serialPortEnable, nineBitTxSelect, txNinthDataBit} = '0;
    {dataWrite, txEmptyIrqEnable, peripheralIrqEnable, globalIrqEnable} = '0;
    {gpioOut, gpioOe, receiveEnable, nineBitRxSelect, addressDetectEnable} = '0;
    {baudDivisorLow, baudDivisorHigh, dataWriteValue} = '0;
    {baudWideDivisorSelect, baudHighSpeedSelect} = 2'h3;
    rnd = 8'h1A;
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    L = bitLen();
    chkLvl(txBufferEmptyFlag, 1'b0, "flag while inactive");
    gpioOe = 1'b1;
    repeat (3) @(negedge clk);
    chkLvl(uat_line_if_inst.lineLevel, 1'b0, "port logic drive");
    chkLvl(gpioIn, 1'b0, "port logic read");
    // Divisor first, then port, then transmit enable, then data.
    serialPortEnable = 1'b1;
    @(negedge clk);
    chkLvl(uat_line_if_inst.lineLevel, 1'b1, "idle mark");
    transmitEnable = 1'b1;
    receiveEnable = 1'b1;
    #1;
    chkLvl(txBufferEmptyFlag, 1'b1, "flag on enable");
    for (int i = 0; i < 8; i++) begin
      {txEmptyIrqEnable, peripheralIrqEnable, globalIrqEnable} = i[2:0];
      #1;
      chkLvl(txIrqRequest, i == 7, "interrupt gating");
      @(negedge clk);
    end
    syncSelect = 1'b1;
    #1;
    chkLvl(txBufferEmptyFlag, 1'b0, "flag in sync mode");
    dataWrite = 1'b1;
    @(negedge clk);
    dataWrite = 1'b0;
    repeat (20) @(negedge clk);
    chkLvl(shifterEmptyStatus, 1'b1, "write taken in sync mode");
    syncSelect = 1'b0;
    // Back-to-back characters: each later one waits behind a busy shifter.
    for (int k = 0; k < 6; k++) begin
      rnd = lfsr(rnd);
      send({1'b0, rnd}, k == 0 ? 0 : 10 * L, 1'b1);
      if (k == 1) begin
        @(negedge clk);
        chkLvl(txBufferEmptyFlag, 1'b0, "flag with queued character");
      end
    end
    waitIdle();
    // The interrupt is dropped once the last character has gone.
    {txEmptyIrqEnable, peripheralIrqEnable, globalIrqEnable} = 3'h0;
    nineBitTxSelect = 1'b1;
    nineBitRxSelect = 1'b1;
    send(9'h1A5, 0, 1'b1);
    send(9'h05A, 11 * L, 1'b1);
    waitIdle();
    addressDetectEnable = 1'b1;
    send(9'h033, 0, 1'b0);
    send(9'h1C3, 0, 1'b1);
    waitIdle();
    {addressDetectEnable, nineBitTxSelect, nineBitRxSelect} = 3'h0;
    // Remaining prescale modes with a non-zero divisor.
    baudDivisorLow = 8'h01;
    for (int m = 0; m < 3; m++) begin
      {baudWideDivisorSelect, baudHighSpeedSelect} = m[1:0];
      L = bitLen();
      rnd = lfsr(rnd);
      send({1'b0, rnd}, 0, 1'b1);
      rnd = lfsr(rnd);
      send({1'b0, rnd}, 10 * L, 1'b1);
      waitIdle();
    end
    end_sim();
  end
endmodule
